// File: hdl/spsel_top.v
// set point selector top: wishbone registers, selectors, ramp, torque limit
// Contract
// - a selector with no active source outputs zero
// - sources: two analogue inputs, serial fixed, CAN fixed, upstream controller output
// - separate selector sets for torque mode and for speed and position modes, switched automatically on mode change
// - speed mode: ramped main plus unramped correcting set point gives total
// - four independent rates by direction and rising or falling
// - link options ==or all follow
// - ramp switchable; off passes steps straight through
// - ramp used in speed mode without positioning, also for external logic
// - torque mode takes torque selector, bypasses ramp, keeps torque limit selector
// - speed mode limit clamps current command symmetrically
// - current bounded by smaller of torque limit and motor current limit
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "spsel_regs.vh"
module spsel_top #(
   parameter W = 16,
   parameter CTRL_DIV = 20
) (
   input wire clk_i,
   input wire rst_i,
   // classic wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [`SPSEL_ADR_W-1:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // set point sources
   input wire [W-1:0] analog_input_first_i,
   input wire [W-1:0] analog_input_second_i,
   input wire [W-1:0] can_speed_i,
   input wire [W-1:0] can_correct_i,
   input wire [W-1:0] can_torque_i,
   input wire [W-1:0] can_limit_i,
   input wire [W-1:0] pos_ctrl_i,
   input wire [W-1:0] speed_ctrl_i,
   // commands to the controllers
   output reg [W-1:0] speed_setpoint_o,
   output reg [W-1:0] current_cmd_o,
   output reg ramp_active_o
);
   // ==========================================================
   // helpers
   function [W-1:0] sabs;
      input [W-1:0] v;
      begin
         sabs = v[W-1] ? (~v + {{(W-1){1'b0}}, 1'b1}) : v;
         // the most negative code has no positive twin; saturate it
         if (sabs[W-1])
            sabs = {1'b0, {(W-1){1'b1}}};
      end
   endfunction
   function [W-1:0] smin;
      input [W-1:0] a;
      input [W-1:0] b;
      begin
         smin = (a < b) ? a : b;
      end
   endfunction
   function [W-1:0] sclamp;
      input [W-1:0] v;
      input [W-1:0] lim;
      reg signed [W-1:0] sv;
      reg signed [W-1:0] sl;
      begin
         sv = v;
         sl = lim;
         if (sv > sl)
            sclamp = lim;
         else if (sv < -sl)
            sclamp = ~lim + {{(W-1){1'b0}}, 1'b1};
         else
            sclamp = v;
      end
   endfunction
   // ==========================================================
   // registers
   reg [1:0] mode_r;
   reg [11:0] sel_spd_r;
   reg [11:0] sel_trq_r;
   reg [4:0] ramp_r;
   reg [W-1:0] r1_r;
   reg [W-1:0] r2_r;
   reg [W-1:0] r3_r;
   reg [W-1:0] r4_r;
   reg [W-1:0] fix_spd_r;
   reg [W-1:0] fix_cor_r;
   reg [W-1:0] fix_trq_r;
   reg [W-1:0] fix_lim_r;
   reg [W-1:0] mot_lim_r;
   wire [W-1:0] ramp_out;
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = req & wb_we_i;
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1)
            merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction
   // ==========================================================
   // register next values; byte lanes merge into the addressed word
   reg [31:0] cur_word;
   reg [31:0] wr_word;
   reg [1:0] mode_nxt;
   reg [11:0] sel_spd_nxt;
   reg [11:0] sel_trq_nxt;
   reg [4:0] ramp_nxt;
   reg [W-1:0] r1_nxt;
   reg [W-1:0] r2_nxt;
   reg [W-1:0] r3_nxt;
   reg [W-1:0] r4_nxt;
   reg [W-1:0] fix_spd_nxt;
   reg [W-1:0] fix_cor_nxt;
   reg [W-1:0] fix_trq_nxt;
   reg [W-1:0] fix_lim_nxt;
   reg [W-1:0] mot_lim_nxt;
   always @* begin
      case (wb_adr_i)
         `SPSEL_A_MODE: cur_word = {30'h0, mode_r};
         `SPSEL_A_SEL_SPD: cur_word = {20'h0, sel_spd_r};
         `SPSEL_A_SEL_TRQ: cur_word = {20'h0, sel_trq_r};
         `SPSEL_A_RAMP: cur_word = {27'h0, ramp_r};
         `SPSEL_A_R1: cur_word = {{(32-W){1'b0}}, r1_r};
         `SPSEL_A_R2: cur_word = {{(32-W){1'b0}}, r2_r};
         `SPSEL_A_R3: cur_word = {{(32-W){1'b0}}, r3_r};
         `SPSEL_A_R4: cur_word = {{(32-W){1'b0}}, r4_r};
         `SPSEL_A_FIX_SPD: cur_word = {{(32-W){1'b0}}, fix_spd_r};
         `SPSEL_A_FIX_COR: cur_word = {{(32-W){1'b0}}, fix_cor_r};
         `SPSEL_A_FIX_TRQ: cur_word = {{(32-W){1'b0}}, fix_trq_r};
         `SPSEL_A_FIX_LIM: cur_word = {{(32-W){1'b0}}, fix_lim_r};
         `SPSEL_A_MOT_LIM: cur_word = {{(32-W){1'b0}}, mot_lim_r};
         `SPSEL_A_RAMP_OUT: cur_word = {{(32-W){1'b0}}, ramp_out};
         `SPSEL_A_SPD_OUT: cur_word = {{(32-W){1'b0}}, speed_setpoint_o};
         `SPSEL_A_CUR_OUT: cur_word = {{(32-W){1'b0}}, current_cmd_o};
         default: cur_word = 32'h0000_0000;
      endcase
      // slices keep the implemented bits only; the rest read back as zero
      wr_word = merge(cur_word, wb_dat_i, wb_sel_i);
      mode_nxt = mode_r;
      sel_spd_nxt = sel_spd_r;
      sel_trq_nxt = sel_trq_r;
      ramp_nxt = ramp_r;
      r1_nxt = r1_r;
      r2_nxt = r2_r;
      r3_nxt = r3_r;
      r4_nxt = r4_r;
      fix_spd_nxt = fix_spd_r;
      fix_cor_nxt = fix_cor_r;
      fix_trq_nxt = fix_trq_r;
      fix_lim_nxt = fix_lim_r;
      mot_lim_nxt = mot_lim_r;
      if (wr) begin
         case (wb_adr_i)
            `SPSEL_A_MODE: mode_nxt = wr_word[1:0];
            `SPSEL_A_SEL_SPD: sel_spd_nxt = wr_word[11:0];
            `SPSEL_A_SEL_TRQ: sel_trq_nxt = wr_word[11:0];
            `SPSEL_A_RAMP: ramp_nxt = wr_word[4:0];
            `SPSEL_A_R1: r1_nxt = wr_word[W-1:0];
            `SPSEL_A_R2: r2_nxt = wr_word[W-1:0];
            `SPSEL_A_R3: r3_nxt = wr_word[W-1:0];
            `SPSEL_A_R4: r4_nxt = wr_word[W-1:0];
            `SPSEL_A_FIX_SPD: fix_spd_nxt = wr_word[W-1:0];
            `SPSEL_A_FIX_COR: fix_cor_nxt = wr_word[W-1:0];
            `SPSEL_A_FIX_TRQ: fix_trq_nxt = wr_word[W-1:0];
            `SPSEL_A_FIX_LIM: fix_lim_nxt = wr_word[W-1:0];
            `SPSEL_A_MOT_LIM: mot_lim_nxt = wr_word[W-1:0];
            default: ;
         endcase
      end
   end
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         mode_r <= `SPSEL_MODE_TRQ;
         sel_spd_r <= 12'h000;
         sel_trq_r <= 12'h000;
         ramp_r <= `SPSEL_RAMP_RST;
         r1_r <= {W{1'b0}};
         r2_r <= {W{1'b0}};
         r3_r <= {W{1'b0}};
         r4_r <= {W{1'b0}};
         fix_spd_r <= {W{1'b0}};
         fix_cor_r <= {W{1'b0}};
         fix_trq_r <= {W{1'b0}};
         fix_lim_r <= {W{1'b0}};
         mot_lim_r <= {W{1'b1}} >> 1;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= cur_word;
         mode_r <= mode_nxt;
         sel_spd_r <= sel_spd_nxt;
         sel_trq_r <= sel_trq_nxt;
         ramp_r <= ramp_nxt;
         r1_r <= r1_nxt;
         r2_r <= r2_nxt;
         r3_r <= r3_nxt;
         r4_r <= r4_nxt;
         fix_spd_r <= fix_spd_nxt;
         fix_cor_r <= fix_cor_nxt;
         fix_trq_r <= fix_trq_nxt;
         fix_lim_r <= fix_lim_nxt;
         mot_lim_r <= mot_lim_nxt;
      end
   end
   // ==========================================================
   // control cycle divider
   reg [15:0] div_r;
   wire step = (div_r == 16'h0000);
   always @(posedge clk_i) begin
      if (rst_i)
         div_r <= 16'h0000;
      else if (step)
         div_r <= CTRL_DIV[15:0] - 16'h0001;
      else
         div_r <= div_r - 16'h0001;
   end
   // ==========================================================
   // selectors; the mode chooses which stored set is live
   wire is_trq = (mode_r == `SPSEL_MODE_TRQ);
   wire [11:0] sel_live = is_trq ? sel_trq_r : sel_spd_r;
   wire [2:0] src_main = sel_live[`SPSEL_F_MAIN +: 3];
   wire [2:0] src_aux = is_trq ? `SPSEL_SRC_OFF : sel_live[`SPSEL_F_AUX +: 3];
   wire [2:0] src_lim = sel_live[`SPSEL_F_LIM +: 3];
   wire [W-1:0] main_v;
   wire [W-1:0] aux_v;
   wire [W-1:0] lim_v;
   spsel_src_mux #(.W(W)) u_main (
      .src_i(src_main),
      .ain0_i(analog_input_first_i),
      .ain1_i(analog_input_second_i),
      .rs232_i(is_trq ? fix_trq_r : fix_spd_r),
      .can_i(is_trq ? can_torque_i : can_speed_i),
      .ctrl_i(is_trq ? speed_ctrl_i : pos_ctrl_i),
      .val_o(main_v)
   );
   spsel_src_mux #(.W(W)) u_aux (
      .src_i(src_aux),
      .ain0_i(analog_input_first_i),
      .ain1_i(analog_input_second_i),
      .rs232_i(fix_cor_r),
      .can_i(can_correct_i),
      .ctrl_i(pos_ctrl_i),
      .val_o(aux_v)
   );
   spsel_src_mux #(.W(W)) u_lim (
      .src_i(src_lim),
      .ain0_i(analog_input_first_i),
      .ain1_i(analog_input_second_i),
      .rs232_i(fix_lim_r),
      .can_i(can_limit_i),
      .ctrl_i({W{1'b0}}),
      .val_o(lim_v)
   );
   // ==========================================================
   // ramp with rate linking
   wire [W-1:0] rate3 = (ramp_r[`SPSEL_B_L31] | ramp_r[`SPSEL_B_LALL]) ? r1_r : r3_r;
   wire [W-1:0] rate2 = ramp_r[`SPSEL_B_LALL] ? r1_r : r2_r;
   wire [W-1:0] rate4 = ramp_r[`SPSEL_B_LALL] ? r1_r : (ramp_r[`SPSEL_B_L42] ? r2_r : r4_r);
   // is kept in hardware: positioning mode disables the ramp here too
   wire ramp_on = ramp_r[`SPSEL_B_RAMP_EN] & (mode_r == `SPSEL_MODE_SPD);
   spsel_ramp #(.W(W)) u_ramp (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .step_i(step),
      .en_i(ramp_on),
      .target_i(main_v),
      .r1_i(r1_r),
      .r2_i(rate2),
      .r3_i(rate3),
      .r4_i(rate4),
      .out_o(ramp_out)
   );
   // ==========================================================
   // outputs
   wire [W-1:0] mot_abs = sabs(mot_lim_r);
   wire [W-1:0] bound = ramp_r[`SPSEL_B_LIM_EN] ? smin(sabs(lim_v), mot_abs) : mot_abs;
   always @(posedge clk_i) begin
      if (rst_i) begin
         speed_setpoint_o <= {W{1'b0}};
         current_cmd_o <= {W{1'b0}};
         ramp_active_o <= 1'b0;
      end else begin
         ramp_active_o <= ramp_on;
         if (is_trq) begin
            speed_setpoint_o <= {W{1'b0}};
            current_cmd_o <= sclamp(main_v, bound);
         end else begin
            speed_setpoint_o <= ramp_out + aux_v;
            current_cmd_o <= sclamp(speed_ctrl_i, bound);
         end
      end
   end
endmodule
`default_nettype wire

// File: hdl/spsel_regs.vh
// register offsets, fields, reset values and timing counts of the set point selector
`ifndef SPSEL_REGS_VH
`define SPSEL_REGS_VH
`define SPSEL_CLK_HZ 20000000
`define SPSEL_CYCLE_NS 50
`define SPSEL_ADR_W 6
// register byte offsets
`define SPSEL_A_MODE 6'h00
`define SPSEL_A_SEL_SPD 6'h04
`define SPSEL_A_SEL_TRQ 6'h08
`define SPSEL_A_RAMP 6'h0c
`define SPSEL_A_R1 6'h10
`define SPSEL_A_R2 6'h14
`define SPSEL_A_R3 6'h18
`define SPSEL_A_R4 6'h1c
`define SPSEL_A_FIX_SPD 6'h20
`define SPSEL_A_FIX_COR 6'h24
`define SPSEL_A_FIX_TRQ 6'h28
`define SPSEL_A_FIX_LIM 6'h2c
`define SPSEL_A_MOT_LIM 6'h30
`define SPSEL_A_RAMP_OUT 6'h34
`define SPSEL_A_SPD_OUT 6'h38
`define SPSEL_A_CUR_OUT 6'h3c
// mode register fields
`define SPSEL_MODE_TRQ 2'h0
`define SPSEL_MODE_SPD 2'h1
`define SPSEL_MODE_POS 2'h2
// source codes, 3 bits each
`define SPSEL_SRC_OFF 3'h0
`define SPSEL_SRC_AIN0 3'h1
`define SPSEL_SRC_AIN1 3'h2
`define SPSEL_SRC_RS232 3'h3
`define SPSEL_SRC_CAN 3'h4
`define SPSEL_SRC_CTRL 3'h5
// selector word field positions (main, correcting, limit)
`define SPSEL_F_MAIN 0
`define SPSEL_F_AUX 4
`define SPSEL_F_LIM 8
// ramp control bits
`define SPSEL_B_RAMP_EN 0
`define SPSEL_B_L31 1
`define SPSEL_B_L42 2
`define SPSEL_B_LALL 3
`define SPSEL_B_LIM_EN 4
`define SPSEL_RAMP_RST 5'h01
`endif

// File: hdl/spsel_src_mux.v
// one set point selector: picks a source code, zero when no source
`timescale 1ns/100ps
`default_nettype none
`include "spsel_regs.vh"
module spsel_src_mux #(
   parameter W = 16
) (
   input wire [2:0] src_i,
   input wire [W-1:0] ain0_i,
   input wire [W-1:0] ain1_i,
   input wire [W-1:0] rs232_i,
   input wire [W-1:0] can_i,
   input wire [W-1:0] ctrl_i,
   output reg [W-1:0] val_o
);
   always @* begin
      case (src_i)
         `SPSEL_SRC_AIN0: val_o = ain0_i;
         `SPSEL_SRC_AIN1: val_o = ain1_i;
         `SPSEL_SRC_RS232: val_o = rs232_i;
         `SPSEL_SRC_CAN: val_o = can_i;
         `SPSEL_SRC_CTRL: val_o = ctrl_i;
         default: val_o = {W{1'b0}};
      endcase
   end
endmodule
`default_nettype wire

// File: hdl/spsel_ramp.v
// four-rate direction dependent speed set point ramp
`timescale 1ns/100ps
`default_nettype none
module spsel_ramp #(
   parameter W = 16
) (
   input wire clk_i,
   input wire rst_i,
   input wire step_i,
   input wire en_i,
   input wire [W-1:0] target_i,
   input wire [W-1:0] r1_i,
   input wire [W-1:0] r2_i,
   input wire [W-1:0] r3_i,
   input wire [W-1:0] r4_i,
   output reg [W-1:0] out_o
);
   wire signed [W:0] cur = {out_o[W-1], out_o};
   wire signed [W:0] tgt = {target_i[W-1], target_i};
   wire up = tgt > cur;
   reg [W-1:0] rate;
   reg signed [W+1:0] nxt;
   always @* begin
      // rate picked by sign of present output and direction of motion
      if (cur > 0 || (cur == 0 && up))
         rate = up ? r1_i : r2_i;
      else
         rate = up ? r4_i : r3_i;
      if (up)
         nxt = {cur[W], cur} + {2'b00, rate};
      else
         nxt = {cur[W], cur} - {2'b00, rate};
      // crossing zero would mix rates; stop at zero first then continue
      // signed compare: a plain concatenation would compare as unsigned across zero
      if ((up && nxt > $signed({tgt[W], tgt})) || (!up && nxt < $signed({tgt[W], tgt})))
         nxt = {tgt[W], tgt};
      if (cur > 0 && nxt < 0 || cur < 0 && nxt > 0)
         nxt = {(W+2){1'b0}};
   end
   always @(posedge clk_i) begin
      if (rst_i)
         out_o <= {W{1'b0}};
      else if (!en_i)
         out_o <= target_i;
      else if (step_i)
         out_o <= nxt[W-1:0];
   end
endmodule
`default_nettype wire

// File: sim/spsel_top_sva.sv
// concurrent checks on the set point selector ports
`timescale 1ns/100ps
`default_nettype none
`include "spsel_regs.vh"
module spsel_top_sva #(
   parameter W = 16,
   parameter CTRL_DIV = 20
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [`SPSEL_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic [W-1:0] speed_setpoint_o,
   input wire logic [W-1:0] current_cmd_o,
   input wire logic ramp_active_o
);
   // ======================================================
   // shadow of the registers the checks depend on
   logic [1:0] q_r;
   logic [1:0] mode_r;
   logic mv_r;
   logic en_r;
   logic [15:0] mot_r;
   wire wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
   wire [16:0] cur_abs = current_cmd_o[W-1] ? 17'h0 - {1'b1, current_cmd_o} : {1'b0, current_cmd_o};
   // quiet counter: outputs lag a register write by one cycle
   always @(posedge clk_i) begin
      if (rst_i) begin
         q_r <= 2'h0;
         mv_r <= 1'b0;
         en_r <= 1'b1;
         mot_r <= 16'h7fff;
      end else begin
         q_r <= wr ? 2'h0 : (q_r == 2'h3 ? q_r : q_r + 2'h1);
         if (wr && wb_adr_i == `SPSEL_A_MODE) begin
            mode_r <= wb_dat_i[1:0];
            mv_r <= 1'b1;
         end
         if (wr && wb_adr_i == `SPSEL_A_RAMP)
            en_r <= wb_dat_i[`SPSEL_B_RAMP_EN];
         if (wr && wb_adr_i == `SPSEL_A_MOT_LIM && wb_sel_i[1])
            mot_r <= wb_dat_i[15:0];
      end
   end
   // ======================================================
   // properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ans;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_ack;
      s_req |=> s_ans;
   endproperty
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   property p_rst;
      disable iff (1'b0) rst_i |=> !wb_ack_o && speed_setpoint_o == 0 && current_cmd_o == 0 && !ramp_active_o;
   endproperty
   property p_sym;
      current_cmd_o != 16'h8000;
   endproperty
   property p_bound;
      q_r == 2'h3 |-> cur_abs <= {1'b0, mot_r};
   endproperty
   property p_ramp_on;
      q_r == 2'h3 && mv_r && mode_r == `SPSEL_MODE_SPD && en_r |-> ramp_active_o;
   endproperty
   property p_ramp_off;
      q_r == 2'h3 && mv_r && (mode_r != `SPSEL_MODE_SPD || !en_r) |-> !ramp_active_o;
   endproperty
   property p_trq_zero;
      q_r == 2'h3 && mv_r && mode_r == `SPSEL_MODE_TRQ |-> speed_setpoint_o == 0;
   endproperty
   a_ack: assert property (p_ack)
      else $error("ack not a single pulse one cycle after the request");
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without a request");
   a_rst: assert property (p_rst)
      else $error("outputs not cleared by reset");
   a_sym: assert property (p_sym)
      else $error("current command outside the symmetric range");
   a_bound: assert property (p_bound)
      else $error("current command above the motor current limit");
   a_ramp_on: assert property (p_ramp_on)
      else $error("ramp idle in speed mode with ramp enabled");
   a_ramp_off: assert property (p_ramp_off)
      else $error("ramp active while disabled or in torque mode");
   a_trq_zero: assert property (p_trq_zero)
      else $error("speed set point not zero in torque mode");
endmodule
bind spsel_top spsel_top_sva #(.W(W), .CTRL_DIV(CTRL_DIV)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .speed_setpoint_o(speed_setpoint_o),
   .current_cmd_o(current_cmd_o), .ramp_active_o(ramp_active_o));
`default_nettype wire

// File: sim/spsel_ain_model.sv
// analogue set point source model feeding both analogue inputs
`timescale 1ns/100ps
`default_nettype none
module spsel_ain_model (
   input wire logic clk_i,
   input wire logic [15:0] lvl0_i,
   input wire logic [15:0] lvl1_i,
   output logic [15:0] ain0_o,
   output logic [15:0] ain1_o
);
   // converter result lands one cycle after the level is applied
   always @(posedge clk_i) begin
      ain0_o <= lvl0_i;
      ain1_o <= lvl1_i;
   end
endmodule
`default_nettype wire

// File: sim/test_spsel_top.sv
// self-checking bench of the set point selector
`timescale 1ns/100ps
`default_nettype none
`include "spsel_regs.vh"
module test_spsel_top;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
   logic [5:0] adr = 0;
   logic [3:0] sel = 0;
   logic [31:0] dat = 0, rdat, r, seed = 32'h6a45, exq[$];
   logic [15:0] l0 = 0, l1 = 0, cs = 0, cc = 0, ct = 0, cl = 0, pc = 0, sc = 0;
   logic [15:0] vals [6] = '{default: 16'h0};
   wire [31:0] dat_o;
   wire ack, ract;
   wire [15:0] spd, cur, a0, a1;
   int bad_count = 0, checks = 0, cyc_n = 0;
   spsel_ain_model u_ain (.clk_i(clk_i), .lvl0_i(l0), .lvl1_i(l1), .ain0_o(a0), .ain1_o(a1));
   spsel_top #(.W(16), .CTRL_DIV(2)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .analog_input_first_i(a0), .analog_input_second_i(a1), .can_speed_i(cs), .can_correct_i(cc),
      .can_torque_i(ct), .can_limit_i(cl), .pos_ctrl_i(pc), .speed_ctrl_i(sc),
      .speed_setpoint_o(spd), .current_cmd_o(cur), .ramp_active_o(ract));
   initial forever #25 clk_i = ~clk_i;
   // ======================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 0;
      stb <= 0;
   endtask
   // settle first: sources pass the source model and an output register
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      repeat (4) @(posedge clk_i);
      exq.push_back(e);
      wb(0, a, 0);
   endtask
   task automatic ramp(input int tg, st, sp, rp, sn, rn);
      int v;
      int seen = 0;
      wb(1, `SPSEL_A_FIX_SPD, tg);
      check("ramp active", ract, 1);
      repeat (200) begin
         wb(0, `SPSEL_A_RAMP_OUT, 0);
         v = $signed(rdat[15:0]);
         if (v != st && v != tg)
            seen++;
         check("ramp range", (v - st) * (v - tg) <= 0, 1);
         check("ramp step", (v == tg || v == 0) ? 0 : (v > 0 ? (v - sp) % rp : (v - sn) % rn), 0);
         if (v == tg) break;
      end
      check("ramp end", v, tg);
      check("ramp travel", seen > 0, 1);
   endtask
   always @(posedge clk_i)
      if (cyc && !we && ack === 1'b1 && exq.size() > 0)
         check("read data", dat_o, exq.pop_front());
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         bad_count++;
         summarize();
      end
   end
   // ======================================================
   // scenarios
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      rd(`SPSEL_A_RAMP, 32'h1);
      rd(`SPSEL_A_MOT_LIM, 32'h7fff);
      wb(1, `SPSEL_A_SPD_OUT, 32'h1234);
      rd(`SPSEL_A_SPD_OUT, 32'h0);
      wb(1, `SPSEL_A_MODE, `SPSEL_MODE_TRQ);
      for (int k = 0; k < 6; k++) begin
         for (int j = 1; j < 6; j++) begin
            r = rnd();
            vals[j] = {{4{r[11]}}, r[11:0]};
         end
         l0 <= vals[1];
         l1 <= vals[2];
         ct <= vals[4];
         sc <= vals[5];
         wb(1, `SPSEL_A_FIX_TRQ, {16'h0, vals[3]});
         wb(1, `SPSEL_A_SEL_TRQ, k);
         rd(`SPSEL_A_CUR_OUT, {16'h0, vals[k]});
         rd(`SPSEL_A_SPD_OUT, 32'h0);
      end
      wb(1, `SPSEL_A_MOT_LIM, 32'h100);
      cl <= 16'h0200;
      wb(1, `SPSEL_A_SEL_TRQ, 32'h401);
      wb(1, `SPSEL_A_SEL_SPD, 32'h343);
      wb(1, `SPSEL_A_FIX_LIM, 32'h80);
      wb(1, `SPSEL_A_RAMP, 32'h10);
      for (int s = 0; s < 2; s++) begin
         l0 <= s ? 16'd1000 : -16'sd1000;
         sc <= s ? 16'd1000 : -16'sd1000;
         wb(1, `SPSEL_A_MODE, `SPSEL_MODE_TRQ);
         rd(`SPSEL_A_CUR_OUT, s ? 32'h100 : 32'hff00);
         wb(1, `SPSEL_A_MODE, `SPSEL_MODE_SPD);
         rd(`SPSEL_A_CUR_OUT, s ? 32'h80 : 32'hff80);
         check("current command", cur, s ? 32'h80 : 32'hff80);
      end
      wb(1, `SPSEL_A_FIX_SPD, 32'd1000);
      cc <= 16'd7;
      rd(`SPSEL_A_SPD_OUT, 32'd1007);
      check("speed set point", spd, 32'd1007);
      check("ramp active", ract, 0);
      wb(1, `SPSEL_A_MODE, `SPSEL_MODE_TRQ);
      rd(`SPSEL_A_SPD_OUT, 32'h0);
      wb(1, `SPSEL_A_MODE, `SPSEL_MODE_SPD);
      rd(`SPSEL_A_SPD_OUT, 32'd1007);
      pc <= 16'd555;
      wb(1, `SPSEL_A_SEL_SPD, 32'h305);
      rd(`SPSEL_A_SPD_OUT, 32'd555);
      wb(1, `SPSEL_A_SEL_SPD, 32'h303);
      wb(1, `SPSEL_A_FIX_SPD, 32'h0);
      rd(`SPSEL_A_SPD_OUT, 32'h0);
      wb(1, `SPSEL_A_R1, 32'd10);
      wb(1, `SPSEL_A_R2, 32'd20);
      wb(1, `SPSEL_A_R3, 32'd7);
      wb(1, `SPSEL_A_R4, 32'd40);
      wb(1, `SPSEL_A_RAMP, 32'h3);
      ramp(95, 0, 0, 10, 0, 1);
      ramp(-95, 95, 95, 20, 0, 10);
      ramp(0, -95, 0, 1, -95, 40);
      wb(1, `SPSEL_A_RAMP, 32'h9);
      ramp(-95, 0, 0, 1, 0, 10);
      wb(1, `SPSEL_A_RAMP, 32'h5);
      ramp(0, -95, 0, 1, -95, 20);
      summarize();
   end
endmodule
`default_nettype wire
